/* src/bbcfg_bank.sv */
// Configuration register bank of the four-switch buck-boost controller.
// Assumes the serial bus engine presents byte accesses as one-cycle strobes.
`timescale 1ns/1ps

// Contract
// R1: Bits 7:6 select sync pin role: input rise/fall, output rise/fall-180.
// R2: Power-stage bit 5 forces constant dead time; resets disabled.
// R3: Power-stage bit 4 enables dead-time frequency scaling; resets enabled.
// R4: Bits 3:2 select minimum dead time 10/20/40/60 ns; reset 20 ns.
// R5: Bits 1:0 scale refresh min time 0.75 to 1.5; reset 1x.
// R6: Unimplemented bits ignore writes and read zero.
// R7: Compensation bits 5:4 select inductor derating; reset 30 percent.
// R8: Compensation bits 3:0 select slope ratio; reset 0.875.
// R9: Feedback bit 7 selects divide ten or twenty; reset twenty.
// R10: Feedback bit 6 enables cable-drop compensation; reset disabled.
// R11: Bits 5:4 select cable-drop gain; reset 0.250 V.
// R12: Bits 3:2 set FET driver sequencing, force on or off.
// R13: Bits 1:0 set FET driver supply; reset open drain.
// R14: Current-set bit 5 forces pin active, disables limit DAC; reset enabled.
// R15: Bits 4:0 set lower window threshold in 2.5 percent steps; reset 30.
// R16: Registers 0xD6 to 0xD9 reset to 0x15, 0x36, 0x84, 0x2C.
// R17: Input overvoltage register at 0xDA resets to 0xFF.
// R18: Overvoltage level is a full read-write byte, 4.75 V plus 0.125 V steps.
// R19: Host accesses single bytes by address; writes take effect on completion.
module bbcfg_bank
   import bbcfg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register access from the serial bus engine
   input wire bbcfg_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic hit,
   // Timing input for dead-time scaling
   input wire logic [3:0] freq_dt_cyc,
   // Configuration to the power stage
   output bbcfg_cfg_t cfg,
   output logic [3:0] dead_time_cyc,
   output logic sync_is_output,
   output logic sync_use_falling,
   output logic current_limit_dac_enable
);
   localparam int NR = BBCFG_NREG;
   localparam logic [7:0] RST_V [NR] = '{RST_PSTAGE, RST_LOOPC, RST_FBCD, RST_CSWIN, RST_IOVP};
   localparam logic [7:0] MASK_V [NR] = '{MASK_PSTAGE, MASK_LOOPC, MASK_FBCD, MASK_CSWIN, MASK_IOVP};

   logic [7:0] regq [NR];
   logic [NR-1:0] sel;

   genvar gi;
   generate
      for (gi = 0; gi < NR; gi++)
      begin : g_reg
         assign sel[gi] = (req.addr == BBCFG_BASE + 8'(gi)); // [R19]
         bbcfg_reg #(
            .RESET_VAL(RST_V[gi]), // [R16] [R17]
            .WR_MASK(MASK_V[gi])
         ) u_reg (
            .clk(clk),
            .arst_n(arst_n),
            .we(req.wr && sel[gi]), // [R19]
            .wdata(req.wdata),
            .q(regq[gi])
         );
      end
   endgenerate

   // Read path and status outputs.
   logic [7:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic hit_r, hit_nxt;

   always_comb
   begin
      rdata_nxt = BBCFG_ZERO;
      rvalid_nxt = req.rd;
      hit_nxt = |sel;
      if (req.rd)
      begin
         for (int i = 0; i < NR; i++)
         begin
            if (sel[i])
            begin
               rdata_nxt = regq[i] & MASK_V[i]; // [R6]
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata_r <= BBCFG_ZERO;
         rvalid_r <= 1'b0;
         hit_r <= 1'b0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         hit_r <= hit_nxt;
      end
   end

   // Field decode of the stored bytes.
   bbcfg_cfg_t cfg_nxt, cfg_r;
   logic [3:0] dt_nxt, dt_r;
   logic sync_out_nxt, sync_out_r;
   logic sync_fall_nxt, sync_fall_r;
   logic dac_en_nxt, dac_en_r;

   bbcfg_deadtime u_dt (
      .min_sel(cfg_nxt.min_dead_time_select),
      .const_en(cfg_nxt.const_dead_time_enable),
      .scale_en(cfg_nxt.dead_time_scaling_enable),
      .freq_dt_cyc(freq_dt_cyc),
      .dead_cyc(dt_nxt)
   );

   always_comb
   begin
      cfg_nxt.sync_pin_role = bbcfg_sync_t'(regq[0][7:6]); // [R1]
      cfg_nxt.const_dead_time_enable = regq[0][5]; // [R2]
      cfg_nxt.dead_time_scaling_enable = regq[0][4]; // [R3]
      cfg_nxt.min_dead_time_select = regq[0][3:2]; // [R4]
      cfg_nxt.refresh_time_scale = regq[0][1:0]; // [R5]
      cfg_nxt.inductor_derating_select = regq[1][5:4]; // [R7]
      cfg_nxt.slope_comp_select = regq[1][3:0]; // [R8]
      cfg_nxt.feedback_divider_select = regq[2][7]; // [R9]
      cfg_nxt.cable_drop_comp_enable = regq[2][6]; // [R10]
      cfg_nxt.cable_drop_comp_gain = regq[2][5:4]; // [R11]
      cfg_nxt.fet_driver_sequencing = bbcfg_seq_t'(regq[2][3:2]); // [R12]
      cfg_nxt.fet_driver_supply = bbcfg_sup_t'(regq[2][1:0]); // [R13]
      cfg_nxt.current_pin_force = regq[3][5]; // [R14]
      cfg_nxt.window_low_select = regq[3][4:0]; // [R15]
      cfg_nxt.input_overvoltage_level = regq[4]; // [R18]
      case (cfg_nxt.sync_pin_role) // [R1]
         SYNC_IN_RISE:
         begin
            sync_out_nxt = 1'b0;
            sync_fall_nxt = 1'b0;
         end
         SYNC_IN_FALL:
         begin
            sync_out_nxt = 1'b0;
            sync_fall_nxt = 1'b1;
         end
         SYNC_OUT_RISE:
         begin
            sync_out_nxt = 1'b1;
            sync_fall_nxt = 1'b0;
         end
         default:
         begin
            sync_out_nxt = 1'b1;
            sync_fall_nxt = 1'b1;
         end
      endcase
      dac_en_nxt = !cfg_nxt.current_pin_force; // [R14]
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_r <= bbcfg_cfg_t'({RST_PSTAGE, RST_LOOPC[5:0], RST_FBCD, RST_CSWIN[5:0], RST_IOVP});
         dt_r <= DT_20_CYC;
         sync_out_r <= 1'b0;
         sync_fall_r <= 1'b0;
         dac_en_r <= 1'b0;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         dt_r <= dt_nxt;
         sync_out_r <= sync_out_nxt;
         sync_fall_r <= sync_fall_nxt;
         dac_en_r <= dac_en_nxt;
      end
   end

   assign rdata = rdata_r;
   assign rvalid = rvalid_r;
   assign hit = hit_r;
   assign cfg = cfg_r;
   assign dead_time_cyc = dt_r;
   assign sync_is_output = sync_out_r;
   assign sync_use_falling = sync_fall_r;
   assign current_limit_dac_enable = dac_en_r;

   // Checks on the read path and the decoded configuration.
   sequence s_wr_pstage;
      req.wr && req.addr == ADDR_PSTAGE;
   endsequence

   a_wr_to_cfg: assert property (@(posedge clk) disable iff (!arst_n) // [R19]
      s_wr_pstage |-> ##2 cfg.refresh_time_scale == $past(req.wdata[1:0], 2))
      else $error("power-stage write did not reach configuration");
   a_unimp_zero: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
      req.rd && (req.addr == ADDR_LOOPC || req.addr == ADDR_CSWIN) |=> rdata[7:6] == 2'h0)
      else $error("unimplemented bits read nonzero");
   a_rd_answer: assert property (@(posedge clk) disable iff (!arst_n) // [R19]
      req.rd |=> rvalid)
      else $error("read not answered next cycle");
   // The decoded outputs load on the same edge as cfg, so they are compared in the same cycle.
   a_sync_role: assert property (@(posedge clk) disable iff (!arst_n) // [R1]
      cfg.sync_pin_role == SYNC_OUT_FALL180 |-> sync_is_output && sync_use_falling)
      else $error("sync role decode wrong");
   a_const_dt: assert property (@(posedge clk) disable iff (!arst_n) // [R2]
      cfg.const_dead_time_enable && cfg.min_dead_time_select == 2'h3 |-> dead_time_cyc == DT_60_CYC)
      else $error("constant dead time not held");
   a_dt_floor: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
      dead_time_cyc >= (cfg.min_dead_time_select[1] ? (cfg.min_dead_time_select[0] ? DT_60_CYC : DT_40_CYC)
         : (cfg.min_dead_time_select[0] ? DT_20_CYC : DT_10_CYC)))
      else $error("dead time under minimum");
   a_dac_off: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
      cfg.current_pin_force |-> !current_limit_dac_enable)
      else $error("limit DAC not disabled");
   a_iovp_rd: assert property (@(posedge clk) disable iff (!arst_n) // [R18]
      req.rd && req.addr == ADDR_IOVP && !req.wr |=> rdata == $past(regq[4]))
      else $error("overvoltage readback mismatch");

   // Each stored byte follows the masked write data one edge after the strobe.
   generate
      for (gi = 0; gi < NR; gi++)
      begin : g_chk
         a_byte_store: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
            req.wr && req.addr == BBCFG_BASE + 8'(gi) |=> regq[gi] == ($past(req.wdata) & MASK_V[gi]))
            else $error("register byte not stored");
      end
   endgenerate

   sequence s_wr_loopc;
      req.wr && req.addr == ADDR_LOOPC;
   endsequence

   sequence s_wr_fbcd;
      req.wr && req.addr == ADDR_FBCD;
   endsequence

   sequence s_wr_cswin;
      req.wr && req.addr == ADDR_CSWIN;
   endsequence

   sequence s_wr_iovp;
      req.wr && req.addr == ADDR_IOVP;
   endsequence

   a_wr_sync: assert property (@(posedge clk) disable iff (!arst_n) // [R1]
      s_wr_pstage |-> ##2 cfg.sync_pin_role == $past(req.wdata[7:6], 2))
      else $error("sync role write not applied");
   a_wr_dt_mode: assert property (@(posedge clk) disable iff (!arst_n) // [R2] [R3]
      s_wr_pstage |-> ##2 {cfg.const_dead_time_enable, cfg.dead_time_scaling_enable} == $past(req.wdata[5:4], 2))
      else $error("dead time mode write not applied");
   a_wr_dt_min: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
      s_wr_pstage |-> ##2 cfg.min_dead_time_select == $past(req.wdata[3:2], 2))
      else $error("minimum dead time write not applied");
   a_wr_derate: assert property (@(posedge clk) disable iff (!arst_n) // [R7]
      s_wr_loopc |-> ##2 cfg.inductor_derating_select == $past(req.wdata[5:4], 2))
      else $error("derating write not applied");
   a_wr_slope: assert property (@(posedge clk) disable iff (!arst_n) // [R8]
      s_wr_loopc |-> ##2 cfg.slope_comp_select == $past(req.wdata[3:0], 2))
      else $error("slope write not applied");
   a_wr_divider: assert property (@(posedge clk) disable iff (!arst_n) // [R9]
      s_wr_fbcd |-> ##2 cfg.feedback_divider_select == $past(req.wdata[7], 2))
      else $error("divider write not applied");
   a_wr_cdc_en: assert property (@(posedge clk) disable iff (!arst_n) // [R10]
      s_wr_fbcd |-> ##2 cfg.cable_drop_comp_enable == $past(req.wdata[6], 2))
      else $error("cable drop enable write not applied");
   a_wr_cable_drop_comp_gain: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
      s_wr_fbcd |-> ##2 cfg.cable_drop_comp_gain == $past(req.wdata[5:4], 2))
      else $error("cable drop gain write not applied");
   a_wr_fet_seq: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
      s_wr_fbcd |-> ##2 cfg.fet_driver_sequencing == $past(req.wdata[3:2], 2))
      else $error("driver sequencing write not applied");
   a_wr_fet_sup: assert property (@(posedge clk) disable iff (!arst_n) // [R13]
      s_wr_fbcd |-> ##2 cfg.fet_driver_supply == $past(req.wdata[1:0], 2))
      else $error("driver supply write not applied");
   a_wr_pin_force: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
      s_wr_cswin |-> ##2 cfg.current_pin_force == $past(req.wdata[5], 2))
      else $error("pin force write not applied");
   a_wr_window: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
      s_wr_cswin |-> ##2 cfg.window_low_select == $past(req.wdata[4:0], 2))
      else $error("window write not applied");
   a_wr_iovp: assert property (@(posedge clk) disable iff (!arst_n) // [R18]
      s_wr_iovp |-> ##2 cfg.input_overvoltage_level == $past(req.wdata, 2))
      else $error("overvoltage write not applied");
   a_dac_on: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
      !cfg.current_pin_force |-> current_limit_dac_enable)
      else $error("limit DAC not enabled");
   a_sync_in_rise: assert property (@(posedge clk) disable iff (!arst_n) // [R1]
      cfg.sync_pin_role == SYNC_IN_RISE |-> !sync_is_output && !sync_use_falling)
      else $error("sync input role decode wrong");
   a_dt_plain: assert property (@(posedge clk) disable iff (!arst_n) // [R3]
      !cfg.const_dead_time_enable && !cfg.dead_time_scaling_enable && cfg.min_dead_time_select == 2'h1
      |-> dead_time_cyc == DT_20_CYC)
      else $error("unscaled dead time not at minimum");
   a_reset_bytes: assert property (@(posedge clk) disable iff (!arst_n) // [R16]
      $rose(arst_n) |-> regq[0] == RST_PSTAGE && regq[1] == RST_LOOPC && regq[2] == RST_FBCD
      && regq[3] == RST_CSWIN)
      else $error("register reset value wrong");
   a_reset_iovp: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
      $rose(arst_n) |-> regq[4] == RST_IOVP)
      else $error("overvoltage reset value wrong");
   a_rd_quiet: assert property (@(posedge clk) disable iff (!arst_n) // [R19]
      !req.rd |=> !rvalid)
      else $error("read answer without request");
   a_rd_unmapped: assert property (@(posedge clk) disable iff (!arst_n) // [R19]
      req.rd && (req.addr < ADDR_PSTAGE || req.addr > ADDR_IOVP) |=> rdata == BBCFG_ZERO)
      else $error("unmapped read nonzero");
   a_hit_in: assert property (@(posedge clk) disable iff (!arst_n) // [R19]
      req.addr >= ADDR_PSTAGE && req.addr <= ADDR_IOVP |=> hit)
      else $error("mapped address not matched");
   a_hit_out: assert property (@(posedge clk) disable iff (!arst_n) // [R19]
      req.addr < ADDR_PSTAGE || req.addr > ADDR_IOVP |=> !hit)
      else $error("unmapped address matched");
endmodule

/* src/bbcfg_pkg.sv */
// Package for the buck-boost configuration register bank.
// Assumes a byte-wide register port driven by the device's serial bus engine.
package bbcfg_pkg;
   localparam int unsigned BBCFG_AW = 8;
   localparam int unsigned BBCFG_DW = 8;
   localparam int unsigned BBCFG_NREG = 5;
   localparam logic [7:0] BBCFG_BASE = 8'hD6;
   localparam logic [7:0] ADDR_PSTAGE = 8'hD6;
   localparam logic [7:0] ADDR_LOOPC = 8'hD7;
   localparam logic [7:0] ADDR_FBCD = 8'hD8;
   localparam logic [7:0] ADDR_CSWIN = 8'hD9;
   localparam logic [7:0] ADDR_IOVP = 8'hDA;
   localparam logic [7:0] RST_PSTAGE = 8'h15;
   localparam logic [7:0] RST_LOOPC = 8'h36;
   localparam logic [7:0] RST_FBCD = 8'h84;
   localparam logic [7:0] RST_CSWIN = 8'h2C;
   localparam logic [7:0] RST_IOVP = 8'hFF;
   // Writable-bit masks; cleared bits are unimplemented and read as zero.
   localparam logic [7:0] MASK_PSTAGE = 8'hFF;
   localparam logic [7:0] MASK_LOOPC = 8'h3F;
   localparam logic [7:0] MASK_FBCD = 8'hFF;
   localparam logic [7:0] MASK_CSWIN = 8'h3F;
   localparam logic [7:0] MASK_IOVP = 8'hFF;
   localparam logic [7:0] BBCFG_ZERO = 8'h00;
   // Dead-time figures in ps, scaled to 200 MHz cycles (5 ns period).
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned DT_10NS_PS = 10000;
   localparam int unsigned DT_20NS_PS = 20000;
   localparam int unsigned DT_40NS_PS = 40000;
   localparam int unsigned DT_60NS_PS = 60000;
   localparam logic [3:0] DT_10_CYC = 4'((DT_10NS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] DT_20_CYC = 4'((DT_20NS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] DT_40_CYC = 4'((DT_40NS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] DT_60_CYC = 4'((DT_60NS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   typedef enum logic [1:0] {SYNC_IN_RISE, SYNC_IN_FALL, SYNC_OUT_RISE, SYNC_OUT_FALL180} bbcfg_sync_t;
   typedef enum logic [1:0] {DRV_SEQ_OFF_ACT, DRV_SEQ_ON_ACT, DRV_SEQ_FORCE_ON, DRV_SEQ_FORCE_OFF} bbcfg_seq_t;
   typedef enum logic [1:0] {DRV_SUP_OPEN_DRAIN, DRV_SUP_VOUT, DRV_SUP_BIAS, DRV_SUP_CPUMP} bbcfg_sup_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bbcfg_req_t;

   typedef struct packed {
      bbcfg_sync_t sync_pin_role;
      logic const_dead_time_enable;
      logic dead_time_scaling_enable;
      logic [1:0] min_dead_time_select;
      logic [1:0] refresh_time_scale;
      logic [1:0] inductor_derating_select;
      logic [3:0] slope_comp_select;
      logic feedback_divider_select;
      logic cable_drop_comp_enable;
      logic [1:0] cable_drop_comp_gain;
      bbcfg_seq_t fet_driver_sequencing;
      bbcfg_sup_t fet_driver_supply;
      logic current_pin_force;
      logic [4:0] window_low_select;
      logic [7:0] input_overvoltage_level;
   } bbcfg_cfg_t;
endpackage

/* src/bbcfg_reg.sv */
// One byte register with a write mask and reset value.
// Assumes write strobes are one cycle wide and synchronous to clk.
`timescale 1ns/1ps
module bbcfg_reg
   import bbcfg_pkg::*;
#(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WR_MASK = 8'hFF
)(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Write port
   input wire logic we,
   input wire logic [7:0] wdata,
   // Stored value
   output logic [7:0] q
);
   logic [7:0] q_r;
   logic [7:0] q_nxt;

   always_comb
   begin
      q_nxt = q_r;
      if (we)
      begin
         q_nxt = wdata & WR_MASK; // [R6] [R19]
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q_r <= RESET_VAL & WR_MASK;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule

/* src/bbcfg_deadtime.sv */
// Turns the dead-time fields into a cycle count for the gate driver.
// Assumes a frequency-derived dead-time count arrives from the timing logic.
`timescale 1ns/1ps
module bbcfg_deadtime
   import bbcfg_pkg::*;
(
   // Controls
   input wire logic [1:0] min_sel,
   input wire logic const_en,
   input wire logic scale_en,
   input wire logic [3:0] freq_dt_cyc,
   // Result
   output logic [3:0] dead_cyc
);
   logic [3:0] min_cyc;

   always_comb
   begin
      case (min_sel) // [R4]
         2'h0: min_cyc = DT_10_CYC;
         2'h1: min_cyc = DT_20_CYC;
         2'h2: min_cyc = DT_40_CYC;
         default: min_cyc = DT_60_CYC;
      endcase
      // Constant mode wins; otherwise scaling stretches the floor with frequency.
      if (const_en)
      begin
         dead_cyc = min_cyc; // [R2]
      end
      else if (scale_en && freq_dt_cyc > min_cyc)
      begin
         dead_cyc = freq_dt_cyc; // [R3]
      end
      else
      begin
         dead_cyc = min_cyc;
      end
   end
endmodule

/* verification/bbcfg_host.sv */
// Behavioural host that issues byte accesses to the configuration register bank.
// Assumes it is called at a falling edge of clk and that the bank takes requests at the rising edge.
`timescale 1ns/1ps
module bbcfg_host
   import bbcfg_pkg::*;
(
   // Clock
   input wire logic clk,
   // Request to the bank
   output bbcfg_req_t req,
   // Answer from the bank
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic hit
);
   initial
   begin
      req = '{1'b0, 1'b0, 8'h00, 8'h00};
   end

   // One single-byte access, held over the taking edge, then one idle cycle.
   task automatic access(input logic do_wr, input logic do_rd, input logic [7:0] addr,
                         input logic [7:0] wdata, output logic [7:0] data, output logic valid,
                         output logic matched);
      req.wr = do_wr;
      req.rd = do_rd;
      req.addr = addr;
      req.wdata = wdata;
      @(negedge clk);
      data = rdata;
      valid = rvalid;
      matched = hit;
      // Idle lines show the inverse so a stale address or byte is never mistaken for a request.
      req.wr = 1'b0;
      req.rd = 1'b0;
      req.addr = ~addr;
      req.wdata = ~wdata;
      @(negedge clk);
   endtask
endmodule

/* verification/bbcfg_bank_test.sv */
// Self-checking testbench for the configuration register bank.
// Assumes the host model in bbcfg_host.sv drives the request port.
`timescale 1ns/1ps
module bbcfg_bank_test;
   import bbcfg_pkg::*;
   logic clk;
   logic arst_n;
   logic [3:0] freq_dt_cyc;
   bbcfg_req_t req;
   logic [7:0] rdata;
   logic rvalid;
   logic hit;
   bbcfg_cfg_t cfg;
   logic [3:0] dead_time_cyc;
   logic sync_is_output;
   logic sync_use_falling;
   logic current_limit_dac_enable;
   int num_errors;
   int checks_done;
   logic [7:0] v;
   logic ok;
   logic h;
   logic [7:0] addr_t [5] = '{8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'hDA};
   logic [7:0] rst_t [5] = '{8'h15, 8'h36, 8'h84, 8'h2C, 8'hFF};
   logic [7:0] mask_t [5] = '{8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF};
   logic [7:0] dt_t [4] = '{8'h02, 8'h04, 8'h08, 8'h0C};

   bbcfg_bank bbcfg_bank_inst (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
      .hit(hit), .freq_dt_cyc(freq_dt_cyc), .cfg(cfg), .dead_time_cyc(dead_time_cyc),
      .sync_is_output(sync_is_output), .sync_use_falling(sync_use_falling),
      .current_limit_dac_enable(current_limit_dac_enable));

   bbcfg_host bbcfg_host_inst (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid), .hit(hit));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      results();
   end

   initial
   begin
      logic [1:0] k;
      arst_n = 1'b0;
      freq_dt_cyc = 4'h0;
      num_errors = 0;
      checks_done = 0;
      repeat (10) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      check(8'(cfg.sync_pin_role), 8'h00);
      check(8'(sync_is_output), 8'h00);
      check(8'(cfg.const_dead_time_enable), 8'h00);
      check(8'(cfg.dead_time_scaling_enable), 8'h01);
      check(8'(dead_time_cyc), 8'h04);
      check(8'(cfg.refresh_time_scale), 8'h01);
      check(8'(cfg.inductor_derating_select), 8'h03);
      check(8'(cfg.slope_comp_select), 8'h06);
      check(8'(cfg.feedback_divider_select), 8'h01);
      check(8'(cfg.cable_drop_comp_enable), 8'h00);
      check(8'(cfg.cable_drop_comp_gain), 8'h00);
      check(8'(cfg.fet_driver_sequencing), 8'h01);
      check(8'(cfg.fet_driver_supply), 8'h00);
      check(8'(current_limit_dac_enable), 8'h00);
      check(8'(cfg.window_low_select), 8'h0C);
      check(cfg.input_overvoltage_level, 8'hFF);
      for (int i = 0; i < 5; i++)
      begin
         bbcfg_host_inst.access(1'b0, 1'b1, addr_t[i], 8'h00, v, ok, h);
         check(v, rst_t[i]);
         check(8'({ok, h}), 8'h03);
         bbcfg_host_inst.access(1'b1, 1'b0, addr_t[i], 8'hFF, v, ok, h);
         bbcfg_host_inst.access(1'b0, 1'b1, addr_t[i], 8'h00, v, ok, h);
         check(v, mask_t[i]);
      end
      // Unmapped addresses on both sides of the bank.
      for (int i = 0; i < 2; i++)
      begin
         bbcfg_host_inst.access(1'b1, 1'b0, i == 0 ? 8'hD5 : 8'hDB, 8'hFF, v, ok, h);
         bbcfg_host_inst.access(1'b0, 1'b1, i == 0 ? 8'hD5 : 8'hDB, 8'h00, v, ok, h);
         check(v, 8'h00);
         check(8'(h), 8'h00);
      end
      freq_dt_cyc = 4'hA;
      for (int i = 0; i < 4; i++)
      begin
         k = 2'(i);
         bbcfg_host_inst.access(1'b1, 1'b0, 8'hD6, {k, k, k, k}, v, ok, h);
         check(8'(cfg.sync_pin_role), 8'(k));
         check(8'({sync_is_output, sync_use_falling}), 8'(k));
         check(8'(cfg.refresh_time_scale), 8'(k));
         if (k == 2'd1)
            check(8'(dead_time_cyc), 8'h0A);
         if (k[1])
            check(8'(dead_time_cyc), dt_t[k]);
         bbcfg_host_inst.access(1'b1, 1'b0, 8'hD7, {k, k, k, k}, v, ok, h);
         bbcfg_host_inst.access(1'b0, 1'b1, 8'hD7, 8'h00, v, ok, h);
         check(v, {2'b00, k, k, k});
         check(8'(cfg.inductor_derating_select), 8'(k));
         check(8'(cfg.slope_comp_select), 8'({k, k}));
         bbcfg_host_inst.access(1'b1, 1'b0, 8'hD8, {k, k, k, k}, v, ok, h);
         check(8'({cfg.feedback_divider_select, cfg.cable_drop_comp_enable}), 8'(k));
         check(8'(cfg.cable_drop_comp_gain), 8'(k));
         check(8'(cfg.fet_driver_sequencing), 8'(k));
         check(8'(cfg.fet_driver_supply), 8'(k));
         bbcfg_host_inst.access(1'b1, 1'b0, 8'hD9, {k, k, k, k}, v, ok, h);
         check(8'({cfg.current_pin_force, current_limit_dac_enable}), 8'({k[1], ~k[1]}));
         check(8'(cfg.window_low_select), 8'({k[0], k, k}));
         bbcfg_host_inst.access(1'b1, 1'b0, 8'hDA, {k, k, k, k}, v, ok, h);
         check(cfg.input_overvoltage_level, {k, k, k, k});
      end
      bbcfg_host_inst.access(1'b1, 1'b0, 8'hD6, 8'h20, v, ok, h);
      check(8'(dead_time_cyc), 8'h02);
      bbcfg_host_inst.access(1'b1, 1'b0, 8'hD6, 8'h1C, v, ok, h);
      check(8'(dead_time_cyc), 8'h0C);
      // With scaling off the frequency-derived count is ignored.
      bbcfg_host_inst.access(1'b1, 1'b0, 8'hD6, 8'h04, v, ok, h);
      check(8'(dead_time_cyc), 8'h04);
      // A read taken with a write in the same cycle returns the old byte.
      bbcfg_host_inst.access(1'b1, 1'b1, 8'hD8, 8'h5A, v, ok, h);
      check(v, 8'hFF);
      bbcfg_host_inst.access(1'b0, 1'b1, 8'hD8, 8'h00, v, ok, h);
      check(v, 8'h5A);
      check(8'(cfg.fet_driver_sequencing), 8'h02);
      // A second reset in mid-run brings every byte back to its reset value.
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      check(8'(cfg.fet_driver_sequencing), 8'h01);
      bbcfg_host_inst.access(1'b0, 1'b1, 8'hD8, 8'h00, v, ok, h);
      check(v, 8'h84);
      bbcfg_host_inst.access(1'b0, 1'b1, 8'hD6, 8'h00, v, ok, h);
      check(v, 8'h15);
      results();
   end
endmodule
